// file: rtl/fpec_pkg.sv
package fpec_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0]  FPEC_OFF_CTRL   = 4'h0;
  localparam logic [3:0]  FPEC_OFF_STAT   = 4'h4;
  localparam logic [3:0]  FPEC_OFF_IEN    = 4'h8;
  localparam logic [3:0]  FPEC_OFF_ICLR   = 4'hC;
  localparam int          FPEC_BIT_START  = 15;
  localparam int          FPEC_BIT_UNLOCK = 14;
  localparam int          FPEC_BIT_FAULT  = 13;
  localparam int          FPEC_BIT_ERASE  = 6;
  localparam logic [15:0] FPEC_CTRL_MASK  = 16'hE04F;
  localparam logic [15:0] FPEC_CTRL_RST   = 16'h0000;
  localparam logic [31:0] FPEC_UNMAPPED   = 32'h0000_0000;

  // ----------------------------------------
  // operation codes
  // ----------------------------------------
  localparam logic [3:0] FPEC_OP_BULK = 4'hF;
  localparam logic [3:0] FPEC_OP_GSEG = 4'hD;
  localparam logic [3:0] FPEC_OP_SSEG = 4'hC;
  localparam logic [3:0] FPEC_OP_PAGE = 4'h2;
  localparam logic [3:0] FPEC_OP_WORD = 4'h3;
  localparam logic [3:0] FPEC_OP_ROW  = 4'h1;
  localparam logic [3:0] FPEC_OP_CFG  = 4'h0;

  // ----------------------------------------
  // operation times in us, cycles at 50 MHz
  // ----------------------------------------
  localparam int FPEC_CLK_MHZ     = 50;
  localparam int FPEC_T_WORD_US   = 40;
  localparam int FPEC_T_ROW_US    = 40;
  localparam int FPEC_T_PAGE_US   = 20;
  localparam int FPEC_T_BULK_US   = 40;
  localparam int FPEC_T_CFG_US    = 40;
  localparam int FPEC_CYC_WORD    = FPEC_T_WORD_US * FPEC_CLK_MHZ;
  localparam int FPEC_CYC_ROW     = FPEC_T_ROW_US * FPEC_CLK_MHZ;
  localparam int FPEC_CYC_PAGE    = FPEC_T_PAGE_US * FPEC_CLK_MHZ;
  localparam int FPEC_CYC_BULK    = FPEC_T_BULK_US * FPEC_CLK_MHZ;
  localparam int FPEC_CYC_CFG     = FPEC_T_CFG_US * FPEC_CLK_MHZ;
  localparam int FPEC_CNT_W       = 16;

  typedef enum logic [2:0] {
    FPEC_K_NONE, FPEC_K_WORD, FPEC_K_ROW, FPEC_K_PAGE,
    FPEC_K_BULK, FPEC_K_SEG, FPEC_K_CFG
  } fpec_kind_t;

  typedef struct packed {
    logic       start;
    logic       unlock;
    logic       fault;
    logic       erase;
    logic [3:0] op;
  } fpec_ctrl_t;

  typedef struct packed {
    logic       req;
    fpec_kind_t kind;
    logic       erase;
    logic [3:0] op;
  } fpec_cmd_t;

endpackage

// file: rtl/fpec_timer.sv
`timescale 1ns/1ps
module fpec_timer (
  input  wire logic                            clk_sys,
  input  wire logic                            rst_n,
  input  wire logic                            load,
  input  wire logic [fpec_pkg::FPEC_CNT_W-1:0] count,
  output logic                                 busy,
  output logic                                 done
);
  logic [fpec_pkg::FPEC_CNT_W-1:0] remain;

  // ----------------------------------------
  // self-timed countdown
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      remain <= '0;
      busy   <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        remain <= count;
        busy   <= 1'b1;
      end else if (busy) begin
        if (remain <= 16'h0001) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        remain <= remain - 16'h0001;
      end
    end
  end
endmodule

// file: rtl/fpec_top.sv
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module fpec_top #(
  parameter int CYC_WORD = fpec_pkg::FPEC_CYC_WORD,
  parameter int CYC_ROW  = fpec_pkg::FPEC_CYC_ROW,
  parameter int CYC_PAGE = fpec_pkg::FPEC_CYC_PAGE,
  parameter int CYC_BULK = fpec_pkg::FPEC_CYC_BULK,
  parameter int CYC_CFG  = fpec_pkg::FPEC_CYC_CFG
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        por_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             flash_start,
  output logic             flash_erase,
  output logic [3:0]       flash_op,
  output logic             done_pulse,
  output logic             error_pulse,
  output logic             irq
);
  fpec_pkg::fpec_ctrl_t ctrl;
  fpec_pkg::fpec_cmd_t  cmd;
  logic [1:0]           stat;
  logic [1:0]           ien;
  logic                 ack;
  logic                 run_busy;
  logic                 run_done;
  logic                 run_load;
  logic [15:0]          run_count;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire acc      = (avs_read | avs_write) & ~ack;
  // write commits at the handshake edge
  wire wr       = avs_write & ack;
  wire lo_en    = avs_byteenable[0];
  wire hi_en    = avs_byteenable[1];
  wire sel_ctrl = avs_address == fpec_pkg::FPEC_OFF_CTRL;
  wire sel_stat = avs_address == fpec_pkg::FPEC_OFF_STAT;
  wire sel_ien  = avs_address == fpec_pkg::FPEC_OFF_IEN;
  wire sel_iclr = avs_address == fpec_pkg::FPEC_OFF_ICLR;
  wire wr_ctrl  = wr & sel_ctrl;
  wire set_try  = wr_ctrl & hi_en & avs_writedata[fpec_pkg::FPEC_BIT_START];

  wire [3:0] op_now = ctrl.op;
  wire       er_now = ctrl.erase;
  wire [2:0] k_erase =
    (op_now == fpec_pkg::FPEC_OP_BULK) ? fpec_pkg::FPEC_K_BULK :
    (op_now == fpec_pkg::FPEC_OP_GSEG) ? fpec_pkg::FPEC_K_SEG  :
    (op_now == fpec_pkg::FPEC_OP_SSEG) ? fpec_pkg::FPEC_K_SEG  :
    (op_now == fpec_pkg::FPEC_OP_PAGE) ? fpec_pkg::FPEC_K_PAGE :
    (op_now == fpec_pkg::FPEC_OP_CFG)  ? fpec_pkg::FPEC_K_CFG  :
                                         fpec_pkg::FPEC_K_NONE;
  wire [2:0] k_prog =
    (op_now == fpec_pkg::FPEC_OP_WORD) ? fpec_pkg::FPEC_K_WORD :
    (op_now == fpec_pkg::FPEC_OP_ROW)  ? fpec_pkg::FPEC_K_ROW  :
    (op_now == fpec_pkg::FPEC_OP_CFG)  ? fpec_pkg::FPEC_K_CFG  :
                                         fpec_pkg::FPEC_K_NONE;
  wire [2:0] kind_raw = er_now ? k_erase : k_prog;
  wire       kind_ok  = kind_raw != fpec_pkg::FPEC_K_NONE;

  wire launch  = set_try & ctrl.unlock & ~ctrl.start & kind_ok;
  wire bad_try = set_try & ~launch & ~ctrl.start;

  wire [15:0] cyc_sel =
    (kind_raw == fpec_pkg::FPEC_K_WORD) ? 16'(CYC_WORD) :
    (kind_raw == fpec_pkg::FPEC_K_ROW)  ? 16'(CYC_ROW)  :
    (kind_raw == fpec_pkg::FPEC_K_PAGE) ? 16'(CYC_PAGE) :
    (kind_raw == fpec_pkg::FPEC_K_CFG)  ? 16'(CYC_CFG)  :
                                          16'(CYC_BULK);

  wire [15:0] ctrl_rd = {ctrl.start, ctrl.unlock, ctrl.fault, 6'h00,
                         ctrl.erase, 2'h0, ctrl.op}
                        & fpec_pkg::FPEC_CTRL_MASK;
  wire [31:0] rd_mux =
    sel_ctrl ? {16'h0000, ctrl_rd} :
    sel_stat ? {30'h0000_0000, stat} :
    sel_ien  ? {30'h0000_0000, ien} :
               fpec_pkg::FPEC_UNMAPPED;

  wire [1:0] ev      = {error_pulse, done_pulse};
  wire [1:0] clr_bit = (wr & sel_iclr & lo_en) ? avs_writedata[1:0] : 2'b00;
  wire [1:0] next_stat = (stat & ~clr_bit) | ev;
  wire       ien_wr    = wr & sel_ien & lo_en;
  wire [1:0] next_ien  = ien_wr ? avs_writedata[1:0] : ien;

  assign run_load  = launch;
  assign run_count = cyc_sel;

  // duration counter
  // timer survives system reset, like start
  fpec_timer fpec_timer_i (
    .clk_sys (clk_sys),
    .rst_n   (por_n),
    .load    (run_load),
    .count   (run_count),
    .busy    (run_busy),
    .done    (run_done)
  );

  // ----------------------------------------
  // avalon slave, one wait state
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~acc;
      if (avs_read & ~ack)
        avs_readdata <= rd_mux;
    end
  end
  assign ack = ~avs_waitrequest;

  // ----------------------------------------
  // control register, power-on reset only
  // ----------------------------------------
  // por-only clear
  always_ff @(posedge clk_sys) begin
    if (!por_n) begin
      ctrl <= fpec_pkg::fpec_ctrl_t'(8'h00);
    end else begin
      if (wr_ctrl & hi_en)
        ctrl.unlock <= avs_writedata[fpec_pkg::FPEC_BIT_UNLOCK];
      if (wr_ctrl & lo_en & ~ctrl.start) begin
        ctrl.erase <= avs_writedata[fpec_pkg::FPEC_BIT_ERASE];
        ctrl.op    <= avs_writedata[3:0];
      end
      if (launch)
        ctrl.start <= 1'b1;
      else if (run_done)
        ctrl.start <= 1'b0;
      if (bad_try)
        ctrl.fault <= 1'b1;
      else if (launch)
        ctrl.fault <= 1'b0;
      else if (wr_ctrl & hi_en & ~avs_writedata[fpec_pkg::FPEC_BIT_FAULT])
        ctrl.fault <= 1'b0;
    end
  end

  // ----------------------------------------
  // events and interrupt
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      done_pulse  <= 1'b0;
      error_pulse <= 1'b0;
      stat        <= 2'b00;
      ien         <= 2'b00;
      irq         <= 1'b0;
      flash_start <= 1'b0;
      flash_erase <= 1'b0;
      flash_op    <= 4'h0;
    end else begin
      done_pulse  <= run_done;
      error_pulse <= bad_try;
      stat        <= next_stat;
      ien         <= next_ien;
      irq         <= |(next_stat & next_ien);
      flash_start <= launch;
      if (launch) begin
        flash_erase <= er_now;
        flash_op    <= op_now;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_START_SET: assert property (@(posedge clk_sys) disable iff (!por_n)
    launch |=> ctrl.start) else $error("start not set on launch");
  AST_START_CLR: assert property (@(posedge clk_sys) disable iff (!por_n)
    run_done |=> !ctrl.start) else $error("start not cleared at done");
  AST_NO_SW_CLR: assert property (@(posedge clk_sys) disable iff (!por_n)
    (ctrl.start && !run_done) |=> ctrl.start)
    else $error("start cleared early");
  AST_LOCKED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (set_try && !ctrl.unlock) |-> !launch) else $error("locked launch");
  AST_FAULT: assert property (@(posedge clk_sys) disable iff (!por_n)
    bad_try |=> ctrl.fault) else $error("fault not set");
  AST_ERASE_BULK: assert property (@(posedge clk_sys)
    (ctrl.erase && ctrl.op == 4'hF) |-> kind_raw == fpec_pkg::FPEC_K_BULK)
    else $error("bulk decode wrong");
  AST_PROG_WORD: assert property (@(posedge clk_sys)
    (!ctrl.erase && ctrl.op == 4'h3) |-> kind_raw == fpec_pkg::FPEC_K_WORD)
    else $error("word decode wrong");
  AST_UNLISTED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ctrl.op == 4'hE) |-> !launch) else $error("reserved launched");
  AST_ZERO_BITS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (avs_read && sel_ctrl && !ack) |=> avs_readdata[12:7] == 6'h00)
    else $error("unimplemented bits nonzero");
  AST_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done_pulse |=> !done_pulse) else $error("done pulse too long");
  AST_ERR_EVENT: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    bad_try |=> error_pulse) else $error("error pulse missing");
  AST_ERR_PULSE: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    error_pulse |=> !error_pulse) else $error("error pulse too long");
  AST_DONE_EVENT: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    run_done |=> done_pulse) else $error("done pulse missing");
  AST_BUSY_START: assert property (
    @(posedge clk_sys) disable iff (!por_n)
    run_busy |-> ctrl.start) else $error("timer runs without start");
  AST_START_HOLD: assert property (
    @(posedge clk_sys) disable iff (!por_n)
    ctrl.start |-> (run_busy || run_done))
    else $error("start set with timer idle");
  AST_OP_FROZEN: assert property (
    @(posedge clk_sys) disable iff (!por_n)
    ctrl.start |=> ($stable(ctrl.op) && $stable(ctrl.erase)))
    else $error("selection changed while busy");
  AST_FLASH_ERASE: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (launch && er_now) |=> (flash_start && flash_erase))
    else $error("erase command not issued");
  AST_FLASH_PROG: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (launch && !er_now) |=> (flash_start && !flash_erase))
    else $error("program command not issued");
  AST_ERASE_PAGE: assert property (
    @(posedge clk_sys) disable iff (!por_n)
    (ctrl.erase && ctrl.op == fpec_pkg::FPEC_OP_PAGE)
    |-> kind_raw == fpec_pkg::FPEC_K_PAGE)
    else $error("page decode wrong");
  AST_PROG_NOOP: assert property (
    @(posedge clk_sys) disable iff (!por_n)
    (!ctrl.erase && ctrl.op == fpec_pkg::FPEC_OP_BULK) |-> !kind_ok)
    else $error("program no-op decoded");
  AST_LOW_ZERO: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (avs_read && sel_ctrl && !ack) |=> avs_readdata[5:4] == 2'b00)
    else $error("unimplemented low bits nonzero");
  AST_IRQ_LEVEL: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    irq == |(stat & ien)) else $error("irq level wrong");
endmodule

// file: verification/fpec_flash_model.sv
`timescale 1ns/1ps
module fpec_flash_model (
  input  wire logic       clk_sys,
  input  wire logic       flash_start,
  input  wire logic       flash_erase,
  input  wire logic [3:0] flash_op,
  input  wire logic       done_pulse,
  output int              starts,
  output int              gap,
  output logic            erase_seen,
  output logic [3:0]      op_seen
);
  // ----
  // flash array: latch command, time it
  // ----
  int run;
  initial begin
    starts = 0;
    gap = 0;
    run = 0;
  end
  always @(posedge clk_sys) begin
    run <= run + 1;
    if (flash_start === 1'b1) begin
      starts <= starts + 1;
      run <= 1;
      erase_seen <= flash_erase;
      op_seen <= flash_op;
    end
    if (done_pulse === 1'b1) begin
      gap <= run;
    end
  end
endmodule

// file: verification/fpec_top_test.sv
`timescale 1ns/1ps
module fpec_top_test;
  // ----
  // bench
  // ----
  logic        clk_sys = 1'b0, rst_n = 1'b0, por_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'h3;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, flash_start, flash_erase;
  logic [3:0]  flash_op;
  logic        done_pulse, error_pulse, irq, erase_seen;
  logic [3:0]  op_seen;
  int          starts, gap, err_total = 0, checks = 0, i, s;
  fpec_top #(.CYC_WORD(8), .CYC_ROW(9), .CYC_PAGE(10), .CYC_BULK(11),
    .CYC_CFG(12)) fpec_top_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .por_n(por_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .flash_start(flash_start),
    .flash_erase(flash_erase), .flash_op(flash_op),
    .done_pulse(done_pulse), .error_pulse(error_pulse), .irq(irq));
  fpec_flash_model fpec_flash_model_i (.clk_sys(clk_sys),
    .flash_start(flash_start), .flash_erase(flash_erase),
    .flash_op(flash_op), .done_pulse(done_pulse), .starts(starts),
    .gap(gap), .erase_seen(erase_seen), .op_seen(op_seen));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  task finish_test;
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d,
           output logic [31:0] q);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n == 50) begin
      err_total++;
      finish_test();
    end
    @(posedge clk_sys);
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, {16'h0000, d}, q);
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, {16'h0000, e});
  endtask
  task launch(input logic e, input logic [3:0] op, input int cyc);
    int n;
    s = starts;
    wr(4'h0, {2'b01, 7'h00, e, 2'b00, op});
    wr(4'h0, {2'b11, 7'h00, e, 2'b00, op});
    wr(4'h0, {2'b01, 7'h00, ~e, 2'b00, ~op});
    rd(4'h0, {2'b11, 7'h00, e, 2'b00, op});
    for (n = 0; n < 100 && done_pulse !== 1'b1; n++) begin
      @(posedge clk_sys);
    end
    if (n == 100) begin
      err_total++;
      finish_test();
    end
    @(posedge clk_sys);
    chk(done_pulse, 1'b0);
    chk(gap, cyc + 1);
    chk(starts, s + 1);
    chk({erase_seen, op_seen}, {e, op});
    rd(4'h0, {2'b01, 7'h00, e, 2'b00, op});
  endtask
  task bad(input logic [15:0] c);
    s = starts;
    wr(4'h0, c);
    wr(4'h0, c | 16'h8000);
    chk(error_pulse, 1'b1);
    rd(4'h0, c | 16'h2000);
    chk(starts, s);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    @(posedge clk_sys);
    rd(4'h0, 16'h0000);
    rd(4'h2, 16'h0000);
    wr(4'h8, 16'h0003);
    wr(4'h0, 16'h5FBF);
    rd(4'h0, 16'h400F);
    wr(4'h0, 16'h0003);
    wr(4'h0, 16'h8003);
    rd(4'h0, 16'h2003);
    chk(starts, 0);
    rd(4'h4, 16'h0002);
    chk(irq, 1'b1);
    wr(4'hC, 16'h0002);
    rd(4'h4, 16'h0000);
    chk(irq, 1'b0);
    bad(16'h4043);
    bad(16'h404E);
    bad(16'h400F);
    bad(16'h400B);
    wr(4'hC, 16'h0002);
    launch(1'b1, 4'hF, 11);
    launch(1'b1, 4'hD, 11);
    launch(1'b1, 4'hC, 11);
    launch(1'b1, 4'h2, 10);
    launch(1'b1, 4'h0, 12);
    launch(1'b0, 4'h3, 8);
    launch(1'b0, 4'h1, 9);
    launch(1'b0, 4'h0, 12);
    rd(4'h4, 16'h0001);
    chk(irq, 1'b1);
    wr(4'h8, 16'h0000);
    chk(irq, 1'b0);
    avs_byteenable <= 4'h1;
    s = starts;
    wr(4'h0, 16'hC003);
    rd(4'h0, 16'h4003);
    chk(starts, s);
    avs_byteenable <= 4'h3;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(4'h0, 16'h4003);
    por_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    por_n <= 1'b1;
    @(posedge clk_sys);
    rd(4'h0, 16'h0000);
    finish_test();
  end
endmodule
